// ### shared/osc_sel_pkg.sv
// constants and types for the primary oscillator mode and clock source selection
// assumes one 25 MHz logic clock and a mode strap that holds still while powered
// Functional notes
// - resistor-capacitor mode drives output pin at input/4
// - resistor-capacitor io mode frees output pin as port bit
// - driven clock mode drives output pin at input/4
// - driven clock io mode frees output pin as port bit
// - driven clock modes switch feedback amplifier off
// - driven clock modes skip any start-up wait
// - crystal modes also accept a driven input clock
// - multiplied mode multiplies fast crystal clock by four
// - multiplier enabled only in fast crystal multiplied mode
// - multiplier is one mode encoding, fixed after programming
// - lock timer holds execution until its time-out
// - three mode bits select one of eight sources
// - lock time-out is nominally two milliseconds
package osc_sel_pkg;

  localparam int MODE_W = 3;

  typedef enum logic [MODE_W-1:0] {
    LOW_POWER_CRYSTAL_MODE        = 3'h0,
    STANDARD_CRYSTAL_MODE         = 3'h1,
    FAST_CRYSTAL_MODE             = 3'h2,
    RESISTOR_CAPACITOR_MODE       = 3'h3,
    DRIVEN_CLOCK_MODE             = 3'h4,
    DRIVEN_CLOCK_IO_MODE          = 3'h5,
    FAST_CRYSTAL_MULTIPLIED_MODE  = 3'h6,
    RESISTOR_CAPACITOR_IO_MODE    = 3'h7
  } osc_mode_t;

  localparam osc_mode_t MODE_RESET = LOW_POWER_CRYSTAL_MODE;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PLL_LOCK_NS     = 2_000_000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_W          = 16;
  localparam int START_EDGES     = 256;
  localparam int START_W         = 9;

  // ------------------------------------------------------------------
  // clock output and multiplier
  // ------------------------------------------------------------------
  localparam int DIV_RATIO  = 4;
  localparam int DIV_HALF   = DIV_RATIO / 2;
  localparam int DIV_W      = 2;
  localparam int MULT_W     = 3;
  localparam logic [MULT_W-1:0] PLL_MULT    = 3'h4;
  localparam logic [MULT_W-1:0] DIRECT_MULT = 3'h1;

  function automatic logic mode_is_crystal(osc_mode_t m);
    return (m == LOW_POWER_CRYSTAL_MODE) || (m == STANDARD_CRYSTAL_MODE) ||
           (m == FAST_CRYSTAL_MODE) || (m == FAST_CRYSTAL_MULTIPLIED_MODE);
  endfunction

  function automatic logic mode_is_driven(osc_mode_t m);
    return (m == DRIVEN_CLOCK_MODE) || (m == DRIVEN_CLOCK_IO_MODE);
  endfunction

  function automatic logic mode_is_gpio(osc_mode_t m);
    return (m == DRIVEN_CLOCK_IO_MODE) || (m == RESISTOR_CAPACITOR_IO_MODE);
  endfunction

  function automatic logic mode_is_clkout(osc_mode_t m);
    return (m == DRIVEN_CLOCK_MODE) || (m == RESISTOR_CAPACITOR_MODE);
  endfunction

endpackage

// ### shared/osc_edge_if.sv
// synchronised pin level and its rising-edge pulse
// assumes producer and consumer share clk_i
`timescale 1ns/100ps
`default_nettype none
interface osc_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface
`default_nettype wire

// ### hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter and rise pulse
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   pin_i,
  osc_edge_if.src     edge_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;
  wire  agree_w = (s2_ff == s3_ff);

  // s1 feeds only s2; metastability stays out of the filter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_ff    <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      s1_ff    <= pin_i;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= agree_w ? s3_ff : level_ff;
      rise_ff  <= agree_w & s3_ff & ~level_ff;
    end
  end

  assign edge_o.level = level_ff;
  assign edge_o.rise  = rise_ff;
endmodule
`default_nettype wire

// ### hdl/clk_div4.sv
// divides a sampled clock by four, counting its rising edges
// assumes edge pulses are at most one per two clk_i cycles
`timescale 1ns/100ps
`default_nettype none
module clk_div4
  import osc_sel_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   clr_i,
  osc_edge_if.dst     edge_i,
  output logic        div_o
);
  logic [DIV_W-1:0] cnt_ff;
  logic             div_ff;
  wire              wrap_w = (cnt_ff == DIV_W'(DIV_HALF - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      cnt_ff <= '0;
      div_ff <= 1'b0;
    end else if (edge_i.rise) begin
      cnt_ff <= wrap_w ? '0 : cnt_ff + 1'b1;
      div_ff <= wrap_w ? ~div_ff : div_ff;
    end
  end

  assign div_o = div_ff;
endmodule
`default_nettype wire

// ### hdl/osc_mode_select.sv
// primary clock source selection: mode strap decode, clock output pin,
// feedback amplifier and multiplier enables, start-up and lock holds
// assumes clk_i is a free-running 25 MHz reference and sleep_i is on clk_i
`timescale 1ns/100ps
`default_nettype none
module osc_mode_select
  import osc_sel_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [MODE_W-1:0] oscillator_mode_field_i,
  input  wire logic              clock_input_pin_i,
  input  wire logic              clock_output_pin_i,
  output logic                   clock_output_pin_o,
  output logic                   clock_output_pin_oe_o,
  input  wire logic              port_a_pin_six_out_i,
  input  wire logic              port_a_pin_six_oe_i,
  output logic                   port_a_pin_six_in_o,
  input  wire logic              sleep_i,
  output logic                   feedback_amp_en_o,
  output logic                   pll_enable_o,
  output logic [MULT_W-1:0]      pll_mult_o,
  output logic                   sys_clk_o,
  output logic                   run_ok_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_LOAD  = 5'h01,
    ST_START = 5'h02,
    ST_LOCK  = 5'h04,
    ST_RUN   = 5'h08,
    ST_SLEEP = 5'h10
  } osc_state_t;

  osc_state_t           state_ff;
  osc_state_t           nxt_state;
  osc_mode_t            mode_ff;
  logic                 mode_valid_ff;
  logic [START_W-1:0]   start_cnt_ff;
  logic [START_W-1:0]   nxt_start_cnt;
  logic [LOCK_W-1:0]    lock_cnt_ff;
  logic [LOCK_W-1:0]    nxt_lock_cnt;
  logic                 clkout_o_ff;
  logic                 clkout_oe_ff;
  logic                 six_in_ff;
  logic                 amp_ff;
  logic                 pll_ff;
  logic [MULT_W-1:0]    mult_ff;
  logic                 sys_clk_ff;
  logic                 run_ff;
  logic                 div_w;

  osc_edge_if in_edge ();
  osc_edge_if out_edge ();

  // ------------------------------------------------------------------
  // pin synchronisers and divider
  // ------------------------------------------------------------------
  pin_sync3 u_sync_in (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (clock_input_pin_i),
    .edge_o  (in_edge)
  );

  pin_sync3 u_sync_out (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (clock_output_pin_i),
    .edge_o  (out_edge)
  );

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  wire crystal_w  = mode_valid_ff & mode_is_crystal(mode_ff);
  wire driven_w   = mode_valid_ff & mode_is_driven(mode_ff);
  wire gpio_w     = mode_valid_ff & mode_is_gpio(mode_ff);
  wire clkout_w   = mode_valid_ff & mode_is_clkout(mode_ff);
  wire pll_mode_w = mode_valid_ff & (mode_ff == FAST_CRYSTAL_MULTIPLIED_MODE);
  wire sleeping_w = (state_ff == ST_SLEEP);
  wire start_done_w = (start_cnt_ff == START_W'(START_EDGES - 1)) & in_edge.rise;
  wire lock_done_w  = (lock_cnt_ff == LOCK_W'(LOCK_CYCLES - 1));
  // crystal modes wait for oscillation; driven and RC modes go straight on
  wire osc_settled_w = ~crystal_w;
  wire div_clr_w  = ~clkout_w | sleeping_w;

  clk_div4 u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (div_clr_w),
    .edge_i  (in_edge),
    .div_o   (div_w)
  );

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_start_cnt = start_cnt_ff;
    nxt_lock_cnt  = lock_cnt_ff;
    case (state_ff)
      ST_LOAD, ST_SLEEP: begin
        nxt_start_cnt = '0;
        nxt_lock_cnt  = '0;
        if (mode_valid_ff && !sleep_i) begin
          nxt_state = osc_settled_w ? ST_RUN : ST_START;
        end
      end
      ST_START: begin
        if (in_edge.rise) begin
          nxt_start_cnt = start_cnt_ff + 1'b1;
        end
        if (start_done_w) begin
          // start-up wait ends here, so the lock count starts from zero
          nxt_lock_cnt = '0;
          nxt_state    = pll_mode_w ? ST_LOCK : ST_RUN;
        end
      end
      ST_LOCK: begin
        nxt_lock_cnt = lock_cnt_ff + 1'b1;
        if (lock_done_w) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_i) begin
          nxt_state = ST_SLEEP;
        end
      end
      default: begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= ST_LOAD;
      start_cnt_ff <= '0;
      lock_cnt_ff  <= '0;
    end else begin
      state_ff     <= nxt_state;
      start_cnt_ff <= nxt_start_cnt;
      lock_cnt_ff  <= nxt_lock_cnt;
    end
  end

  // strap caught once after reset release, then frozen
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_ff       <= MODE_RESET;
      mode_valid_ff <= 1'b0;
    end else if (!mode_valid_ff) begin
      mode_ff       <= osc_mode_t'(oscillator_mode_field_i);
      mode_valid_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // pin and enable outputs
  // ------------------------------------------------------------------
  // in io modes the pad belongs to port a; sleep parks the clock low
  wire pin_o_w  = gpio_w ? port_a_pin_six_out_i : (clkout_w & ~sleeping_w & div_w);
  wire pin_oe_w = gpio_w ? port_a_pin_six_oe_i : clkout_w;
  // amplifier only serves crystals; an overdriven crystal input still works
  wire amp_w    = crystal_w & ~sleeping_w;
  wire pll_w    = pll_mode_w & ~sleeping_w;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clkout_o_ff  <= 1'b0;
      clkout_oe_ff <= 1'b0;
      six_in_ff    <= 1'b0;
      amp_ff       <= 1'b0;
      pll_ff       <= 1'b0;
      mult_ff      <= DIRECT_MULT;
      sys_clk_ff   <= 1'b0;
      run_ff       <= 1'b0;
    end else begin
      clkout_o_ff  <= pin_o_w;
      clkout_oe_ff <= pin_oe_w;
      six_in_ff    <= gpio_w & out_edge.level;
      amp_ff       <= amp_w;
      pll_ff       <= pll_w;
      mult_ff      <= pll_w ? PLL_MULT : DIRECT_MULT;
      sys_clk_ff   <= in_edge.level;
      run_ff       <= (state_ff == ST_RUN);
    end
  end

  assign clock_output_pin_o    = clkout_o_ff;
  assign clock_output_pin_oe_o = clkout_oe_ff;
  assign port_a_pin_six_in_o   = six_in_ff;
  assign feedback_amp_en_o     = amp_ff;
  assign pll_enable_o          = pll_ff;
  assign pll_mult_o            = mult_ff;
  assign sys_clk_o             = sys_clk_ff;
  assign run_ok_o              = run_ff;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_clkout_div_four: assert property (
    clkout_w && !sleeping_w && !gpio_w |=> clock_output_pin_oe_o && (clock_output_pin_o == $past(div_w)))
    else $error("clock output pin not carrying divided clock");

  a_gpio_pass_thru: assert property (
    gpio_w |=> (clock_output_pin_o == $past(port_a_pin_six_out_i)) &&
               (clock_output_pin_oe_o == $past(port_a_pin_six_oe_i)))
    else $error("port bit six not passed to clock output pin");

  a_div_rate: assert property (
    clkout_w && !sleeping_w && in_edge.rise && u_div.cnt_ff == DIV_W'(DIV_HALF - 1)
      |=> div_w != $past(div_w))
    else $error("divider did not toggle on second edge");

  a_amp_off_driven: assert property (
    driven_w || !crystal_w |=> !feedback_amp_en_o)
    else $error("feedback amplifier on outside crystal modes");

  a_no_start_wait: assert property (
    (state_ff == ST_LOAD || state_ff == ST_SLEEP) && driven_w && !sleep_i |=> ##1 run_ok_o)
    else $error("driven clock mode applied a start-up wait");

  a_mult_four: assert property (
    pll_enable_o |-> (pll_mult_o == PLL_MULT) && (mode_ff == FAST_CRYSTAL_MULTIPLIED_MODE))
    else $error("multiplier enabled with wrong factor or mode");

  a_pll_only_fast: assert property (
    !pll_mode_w |=> !pll_enable_o && (pll_mult_o == DIRECT_MULT))
    else $error("multiplier active outside its mode");

  a_mode_fixed: assert property (
    mode_valid_ff |=> $stable(mode_ff) && mode_valid_ff)
    else $error("mode field changed at run time");

  a_lock_holds: assert property (
    state_ff == ST_LOCK |=> !run_ok_o)
    else $error("execution released during lock wait");

  a_lock_terminal: assert property (
    state_ff == ST_LOCK && nxt_state == ST_RUN |-> lock_cnt_ff == LOCK_W'(LOCK_CYCLES - 1))
    else $error("lock released before terminal count");

  a_lock_restart: assert property (
    state_ff == ST_START && nxt_state == ST_LOCK |=> lock_cnt_ff == '0)
    else $error("lock counter not restarted");

  // own count of lock cycles, so the length check does not trust lock_cnt_ff
  logic [LOCK_W-1:0] lock_len_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_len_ff <= '0;
    end else if (state_ff == ST_LOCK) begin
      lock_len_ff <= lock_len_ff + 1'b1;
    end else begin
      lock_len_ff <= '0;
    end
  end

  a_lock_length: assert property (
    state_ff == ST_LOCK && nxt_state == ST_RUN |-> lock_len_ff == LOCK_W'(LOCK_CYCLES - 1))
    else $error("lock wait differs from its time-out");

  a_pll_then_lock: assert property (
    state_ff == ST_START && start_done_w && pll_mode_w |=> state_ff == ST_LOCK && !run_ok_o)
    else $error("multiplied mode skipped the lock wait");

  a_sleep_pin_low: assert property (
    sleeping_w && !gpio_w |=> !clock_output_pin_o)
    else $error("clock output pin not low in sleep");

  a_clkout_enable: assert property (
    clkout_w |=> clock_output_pin_oe_o)
    else $error("clock output pin not driven in divided modes");

  a_crystal_pin_free: assert property (
    crystal_w |=> !clock_output_pin_oe_o)
    else $error("clock output pin driven in a crystal mode");

  a_crystal_amp_on: assert property (
    crystal_w && !sleeping_w |=> feedback_amp_en_o)
    else $error("feedback amplifier off in a crystal mode");

  a_sys_clk_direct: assert property (
    1'b1 |=> sys_clk_o == $past(in_edge.level))
    else $error("system clock not taken from clock input pin");

  a_port_six_read: assert property (
    gpio_w |=> port_a_pin_six_in_o == $past(out_edge.level))
    else $error("port bit six not read from clock output pin");

  a_port_six_idle: assert property (
    !gpio_w |=> !port_a_pin_six_in_o)
    else $error("port bit six read outside io modes");

endmodule
`default_nettype wire

// ### verif/osc_source_model.sv
// external clock source at the clock input pin, timed in clk_i cycles
// assumes a half period of at least 3 cycles so the device sees clean edges
`timescale 1ns/100ps
`default_nettype none
module osc_source_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  output logic            clk_pin_o,
  output int              rises_o
);
  int cnt;

  initial begin
    clk_pin_o = 1'b0;
    rises_o = 0;
    cnt = 0;
  end

  // stands still low while stopped, as the pin does in sleep
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      clk_pin_o <= 1'b0;
    end else if (cnt + 1 >= int'(half_i)) begin
      cnt <= 0;
      clk_pin_o <= ~clk_pin_o;
      if (!clk_pin_o) rises_o <= rises_o + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the oscillator mode selection block
// assumes the source model drives the clock input pin
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import osc_sel_pkg::*;
  localparam int LOCK = 20;
  logic              clk_i;
  logic              rst_n_i;
  logic [MODE_W-1:0] mode;
  logic              src_clk;
  logic              run_src;
  logic [3:0]        half;
  logic              pad;
  logic              pad_ext;
  logic              p6_out;
  logic              p6_oe;
  logic              sleep;
  logic              pin_o;
  logic              pin_oe;
  logic              p6_in;
  logic              amp;
  logic              pll_en;
  logic [MULT_W-1:0] mult;
  logic              run_ok;
  logic              sys_clk;
  int                rises;
  int                failures;
  int                compares;
  int                cyc;

  // pad level: device drives when enabled, else the board
  assign pad = pin_oe ? pin_o : pad_ext;

  osc_source_model u_src (
    .clk_i    (clk_i),
    .run_i    (run_src),
    .half_i   (half),
    .clk_pin_o(src_clk),
    .rises_o  (rises)
  );

  osc_mode_select #(.LOCK_CYCLES(LOCK)) u_dut (
    .clk_i                  (clk_i),
    .rst_n_i                (rst_n_i),
    .oscillator_mode_field_i(mode),
    .clock_input_pin_i      (src_clk),
    .clock_output_pin_i     (pad),
    .clock_output_pin_o     (pin_o),
    .clock_output_pin_oe_o  (pin_oe),
    .port_a_pin_six_out_i   (p6_out),
    .port_a_pin_six_oe_i    (p6_oe),
    .port_a_pin_six_in_o    (p6_in),
    .sleep_i                (sleep),
    .feedback_amp_en_o      (amp),
    .pll_enable_o           (pll_en),
    .pll_mult_o             (mult),
    .sys_clk_o              (sys_clk),
    .run_ok_o               (run_ok)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  always #20 clk_i = ~clk_i;

  task automatic end_sim();
    $display("Counts: failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ceiling well above eight modes of start-up and divider runs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 90000) begin
      $display("Error timeout expected %0d seen %0d", 90000, cyc);
      failures++;
      end_sim();
    end
  end

  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (exp !== got) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc_n(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // crystal start: no run before the edge count, then lock time only if multiplied
  // base is the source rise count taken when the source was restarted
  task automatic start_wait(logic mul, int base);
    int n;
    while (rises - base < 250) cyc_n(1);
    chk("early_run", 0, run_ok);
    while (rises - base < 256) cyc_n(1);
    n = 0;
    while (run_ok !== 1'b1 && n < LOCK + 40) begin
      cyc_n(1);
      n++;
    end
    chk("lock_wait", 1, mul ? (n >= LOCK && n < LOCK + 12) : (n < 12));
  endtask

  // over 64 source rises: pin rises a quarter as often in divided modes, else never
  task automatic div_check(logic co);
    int base;
    int k;
    int s;
    logic prv;
    logic prv_s;
    base = rises;
    k = 0;
    s = 0;
    prv = pin_o;
    prv_s = sys_clk;
    while (rises - base < 64) begin
      cyc_n(1);
      if (pin_o === 1'b1 && prv === 1'b0) k++;
      if (sys_clk === 1'b1 && prv_s === 1'b0) s++;
      prv = pin_o;
      prv_s = sys_clk;
    end
    chk("div_rises", 1, co ? (k >= 15 && k <= 17) : (k == 0));
    chk("sys_rises", 1, s >= 63 && s <= 65);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic cr;
    logic co;
    logic io;
    logic pm;
    int   b;
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    mode = '0;
    run_src = 1'b0;
    half = 4'h3;
    pad_ext = 1'b0;
    p6_out = 1'b0;
    p6_oe = 1'b0;
    sleep = 1'b0;
    failures = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h29BE3C41));
    for (int m = 0; m < 8; m++) begin
      pm = (m == FAST_CRYSTAL_MULTIPLIED_MODE);
      cr = pm || (m == LOW_POWER_CRYSTAL_MODE) || (m == STANDARD_CRYSTAL_MODE) || (m == FAST_CRYSTAL_MODE);
      co = (m == RESISTOR_CAPACITOR_MODE) || (m == DRIVEN_CLOCK_MODE);
      io = (m == RESISTOR_CAPACITOR_IO_MODE) || (m == DRIVEN_CLOCK_IO_MODE);
      mode = m[MODE_W-1:0];
      run_src = 1'b0;
      sleep = 1'b0;
      half = 4'(3 + $urandom % 4);
      rst_n_i = 1'b0;
      cyc_n(20);
      rst_n_i = 1'b1;
      cyc_n(4);
      chk("amp_en", cr, amp);
      chk("pll_en", pm, pll_en);
      chk("pll_mult", pm ? 4'h4 : 4'h1, mult);
      mode = MODE_W'($urandom);
      if (cr) begin
        cyc_n(40);
        chk("hold_stopped", 0, run_ok);
        run_src = 1'b1;
        start_wait(pm, rises);
      end else begin
        chk("no_wait", 1, run_ok);
        run_src = 1'b1;
      end
      chk("pin_oe", co, pin_oe);
      div_check(co);
      if (io) begin
        for (int i = 0; i < 8; i++) begin
          p6_out = 1'($urandom);
          p6_oe = 1'($urandom);
          pad_ext = 1'($urandom);
          cyc_n(6);
          chk("p6_drive", {p6_oe, p6_out}, {pin_oe, pin_o});
          chk("p6_read", pad, p6_in);
        end
        p6_oe = 1'b0;
        p6_out = 1'b0;
      end
      chk("mode_frozen", pm, pll_en);
      sleep = 1'b1;
      run_src = 1'b0;
      cyc_n(3);
      chk("sleep_run", 0, run_ok);
      chk("sleep_amp", 0, {amp, pll_en});
      if (co) chk("sleep_pin", 0, pin_o);
      // rises seen from here on are the ones the wake count sees
      b = rises;
      sleep = 1'b0;
      run_src = 1'b1;
      if (cr) begin
        cyc_n(20);
        chk("wake_hold", 0, run_ok);
        start_wait(pm, b);
      end else begin
        cyc_n(3);
        chk("wake_no_wait", 1, run_ok);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
